// ==== hold_grant_pkg.sv ====
// package for the external bus hold/grant block
// assumes a single 100 MHz cpu clock domain
package hold_grant_pkg;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS     = 10;
  localparam int FLOAT_MIN_P       = 3;   // periods, request to float
  localparam int RESUME_MIN_P      = 3;   // periods, release to drive
  localparam int RESUME_MAX_P      = 7;
  localparam int GRANT_LAG_MAX_P   = 2;
  localparam int FLOAT_MIN_CYC     = FLOAT_MIN_P;
  localparam int RESUME_MIN_CYC    = RESUME_MIN_P;
  localparam int SYNC_STAGES       = 2;
  localparam logic [2:0] FLOAT_WAIT_RST = 3'h0;

  // ----------------------------------------------------------------------
  // memory port signal group
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [3:0]  space_select_n;
    logic [3:0]  byte_lane_strobe;
    logic [31:0] ext_data;
    logic [19:0] ext_word_address;
    logic        async_read_strobe;
    logic        async_output_enable;
    logic        async_write_strobe;
    logic        column_or_burst_addr_strobe;
    logic        row_or_sync_output_strobe;
    logic        sync_write_strobe;
    logic        precharge_address_bit;
  } mem_port_t;

  localparam int MEM_PORT_W = $bits(mem_port_t);

  typedef enum logic [2:0] {
    ST_OWN, ST_DRAIN, ST_FLOAT_WAIT, ST_HELD, ST_RESUME_WAIT
  } hold_state_t;

endpackage : hold_grant_pkg

// ==== external_bus_hold_grant.sv ====
// bus hold/grant arbiter between the memory controller and an outside master
// assumes the controller reports a busy level covering any pending transaction
// Summary of operation
// - float port at least three clocks after request
// - grant low within two clocks of float
// - redrive port three to seven clocks after release
// - grant high within two clocks of redrive
// - pending transactions finish before the grant
// - long accesses and bursts stretch the wait
// - idle bus grants with minimum delay
// - hold_disable withholds the grant indefinitely
// - floated set is the whole memory port
// - shared strobes act as sdram commands
`timescale 1ns/100ps
module external_bus_hold_grant
  import hold_grant_pkg::*;
(
  input  wire logic                  SYS_CLK,
  input  wire logic                  RSTN,
  input  wire logic                  EXT_BUS_REQUEST_N,
  input  wire logic                  HOLD_DISABLE,
  input  wire logic                  MEM_BUSY,
  input  wire mem_port_t             MEM_PORT_IN,
  output logic      [MEM_PORT_W-1:0] MEM_PORT_OUT,
  output logic      [MEM_PORT_W-1:0] MEM_PORT_OE,
  output logic                       EXTERNAL_BUS_GRANT_N,
  output logic                       MEM_HOLD_STALL
);

  // ----------------------------------------------------------------------
  // request synchroniser
  // ----------------------------------------------------------------------
  logic sync1_q, sync2_q;
  logic sync1_d, sync2_d;

  always_comb begin
    sync1_d = EXT_BUS_REQUEST_N;
    sync2_d = sync1_q;
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
    end
  end

  wire req_active = ~sync2_q;

  // ----------------------------------------------------------------------
  // hold sequencer
  // ----------------------------------------------------------------------
  // the two synchroniser stages plus two state cycles (drain, float) put the float four clocks after request, above the 3-clock floor
  hold_state_t state_q, state_d;
  logic [2:0]  wait_q, wait_d;
  logic        float_q, float_d;
  // grant lives in its own active-low flop so the pin has no gate behind it
  logic        grant_n_q, grant_n_d;
  logic        stall_q, stall_d;

  always_comb begin
    state_d = state_q;
    wait_d  = wait_q;
    float_d = float_q;
    grant_n_d = grant_n_q;
    stall_d = stall_q;
    case (state_q)
      ST_OWN: begin
        stall_d = 1'b0;
        if (req_active && !HOLD_DISABLE) begin
          state_d = ST_DRAIN;
          stall_d = 1'b1;
        end
      end
      ST_DRAIN: begin
        // busy covers async_ready stretches and sdram bursts alike
        if (!req_active || HOLD_DISABLE) begin
          state_d = ST_OWN;
          stall_d = 1'b0;
        end else if (!MEM_BUSY) begin
          state_d = ST_FLOAT_WAIT;
          float_d = 1'b1;
        end
      end
      ST_FLOAT_WAIT: begin
        grant_n_d = 1'b0;
        state_d = ST_HELD;
      end
      ST_HELD: begin
        if (!req_active) begin
          state_d = ST_RESUME_WAIT;
          wait_d  = FLOAT_WAIT_RST;
        end
      end
      ST_RESUME_WAIT: begin
        // count starts behind the synchroniser, so redrive lands five clocks after release
        wait_d = wait_q + 3'h1;
        if (wait_q == 3'(RESUME_MIN_CYC - SYNC_STAGES)) begin
          float_d = 1'b0;
          grant_n_d = 1'b1;
          stall_d = 1'b0;
          state_d = ST_OWN;
        end
      end
      default: state_d = ST_OWN;
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      state_q <= ST_OWN;
      wait_q  <= FLOAT_WAIT_RST;
      float_q <= 1'b0;
      grant_n_q <= 1'b1;
      stall_q <= 1'b0;
    end else begin
      state_q <= state_d;
      wait_q  <= wait_d;
      float_q <= float_d;
      grant_n_q <= grant_n_d;
      stall_q <= stall_d;
    end
  end

  // ----------------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------------
  // shared strobes pass straight through, so sdram commands keep their meaning
  logic [MEM_PORT_W-1:0] port_q, port_d, oe_q, oe_d;

  always_comb begin
    port_d = MEM_PORT_IN;
    oe_d   = float_d ? '0 : '1;
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      port_q <= '0;
      oe_q   <= '0;
    end else begin
      port_q <= port_d;
      oe_q   <= oe_d;
    end
  end

  assign MEM_PORT_OUT         = port_q;
  assign MEM_PORT_OE          = oe_q;
  assign EXTERNAL_BUS_GRANT_N = grant_n_q;
  assign MEM_HOLD_STALL       = stall_q;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  sequence s_float;
    $fell(oe_q[0]);
  endsequence

  AST_FLOAT_MIN: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    $fell(EXT_BUS_REQUEST_N) |-> oe_q[0] [*3])
    else $error("port floated too soon after request");

  AST_GRANT_AFTER_FLOAT: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    s_float |-> ##[0:2] !EXTERNAL_BUS_GRANT_N)
    else $error("grant late after float");

  AST_RESUME_WINDOW: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    (state_q == ST_HELD && sync2_q) |-> ##[1:5] oe_q[0])
    else $error("port not redriven in time");

  AST_GRANT_RELEASE: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    $rose(oe_q[0]) |-> ##[0:2] EXTERNAL_BUS_GRANT_N)
    else $error("grant not released after redrive");

  AST_NO_FLOAT_BUSY: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    (state_q == ST_DRAIN && MEM_BUSY) |=> oe_q[0])
    else $error("floated with transaction pending");

  AST_IDLE_FAST: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    (state_q == ST_DRAIN && !MEM_BUSY && req_active && !HOLD_DISABLE) |=> ##1 !EXTERNAL_BUS_GRANT_N)
    else $error("idle grant not minimal");

  AST_HOLD_DISABLE: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    (HOLD_DISABLE && state_q == ST_OWN) |=> state_q == ST_OWN)
    else $error("grant path entered while disabled");

  AST_GRANT_IMPLIES_FLOAT: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    !EXTERNAL_BUS_GRANT_N |-> (oe_q == '0))
    else $error("granted while port driven");

  AST_RESET_GRANT: assert property (@(posedge SYS_CLK)
    !RSTN |=> EXTERNAL_BUS_GRANT_N)
    else $error("grant asserted out of reset");

  // the redrive must not start inside the first three release periods
  sequence s_release_seen;
    state_q == ST_HELD && sync2_q;
  endsequence

  sequence s_still_floated;
    !oe_q[0] [*3];
  endsequence

  AST_RESUME_MIN: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    s_release_seen |-> s_still_floated)
    else $error("port redriven too soon after release");

  AST_STALL_BEFORE_FLOAT: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    s_float |-> MEM_HOLD_STALL)
    else $error("port floated without stalling the controller");

  AST_STALL_WHILE_HELD: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    !EXTERNAL_BUS_GRANT_N |-> MEM_HOLD_STALL)
    else $error("controller released while bus granted");

  AST_ABORT_DRAIN: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    (state_q == ST_DRAIN && !req_active) |=> (state_q == ST_OWN && oe_q[0]))
    else $error("withdrawn request not abandoned");

endmodule : external_bus_hold_grant

// ==== bus_master_model.sv ====
// outside master that borrows the memory bus through the request/grant pair
// assumes go is a level from the bench, sampled on the rising clock edge
`timescale 1ns/100ps
module bus_master_model (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic go,
  input  wire logic grant_n,
  output logic      req_n
);
  logic seen_q;
  logic seen_d;
  logic req_d;
  // ----------------------------------------------------------------------
  // request level
  // ----------------------------------------------------------------------
  always_comb begin
    seen_d = !grant_n;
    req_d  = req_n;
    if (go) begin
      req_d = 1'b0;
    end else if (seen_q || grant_n) begin
      // never let go in the edge the grant first shows low
      req_d = 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      seen_q <= 1'b0;
      req_n  <= 1'b1;
    end else begin
      seen_q <= seen_d;
      req_n  <= req_d;
    end
  end
endmodule : bus_master_model

// ==== external_bus_hold_grant_test.sv ====
// self-checking bench for the hold/grant block
// assumes the partner model drives the request; bench drives the rest
`timescale 1ns/100ps
module external_bus_hold_grant_test
  import hold_grant_pkg::*;
;
  localparam logic [MEM_PORT_W-1:0] ONES = '1;
  logic                  SYS_CLK = 1'b0;
  logic                  RSTN = 1'b0;
  logic                  HOLD_DISABLE = 1'b0;
  logic                  MEM_BUSY = 1'b0;
  logic                  go = 1'b0;
  mem_port_t             MEM_PORT_IN = '0;
  logic [95:0]           rnd;
  logic [MEM_PORT_W-1:0] MEM_PORT_OUT, MEM_PORT_OE, e;
  logic                  EXTERNAL_BUS_GRANT_N, MEM_HOLD_STALL, EXT_BUS_REQUEST_N;
  int                    n_mismatch = 0;
  int                    n_checks = 0;
  bit                    seeded = 1'b0;
  mem_port_t             exp_q[$];
  always #(CLK_PERIOD_NS / 2) SYS_CLK = ~SYS_CLK;
  external_bus_hold_grant dut (.SYS_CLK(SYS_CLK), .RSTN(RSTN), .EXT_BUS_REQUEST_N(EXT_BUS_REQUEST_N),
    .HOLD_DISABLE(HOLD_DISABLE), .MEM_BUSY(MEM_BUSY), .MEM_PORT_IN(MEM_PORT_IN), .MEM_PORT_OUT(MEM_PORT_OUT),
    .MEM_PORT_OE(MEM_PORT_OE), .EXTERNAL_BUS_GRANT_N(EXTERNAL_BUS_GRANT_N), .MEM_HOLD_STALL(MEM_HOLD_STALL));
  bus_master_model master (.clk(SYS_CLK), .rst_n(RSTN), .go(go), .grant_n(EXTERNAL_BUS_GRANT_N),
    .req_n(EXT_BUS_REQUEST_N));
  task automatic check(input logic [MEM_PORT_W-1:0] got, input logic [MEM_PORT_W-1:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask : check
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report
  // cycles until the watched output reaches want, capped at 20
  task automatic cnt(input bit g, input logic [MEM_PORT_W-1:0] want, output int n);
    n = 0;
    while ((g ? {{(MEM_PORT_W-1){1'b0}}, EXTERNAL_BUS_GRANT_N} : MEM_PORT_OE) !== want && n < 20) begin
      @(negedge SYS_CLK);
      n++;
    end
  endtask : cnt
  task automatic wreq(input logic lvl);
    while (EXT_BUS_REQUEST_N !== lvl) @(negedge SYS_CLK);
  endtask : wreq
  task automatic run(input int busy);
    int n;
    @(posedge SYS_CLK);
    go <= 1'b1;
    MEM_BUSY <= (busy > 0);
    wreq(1'b0);
    if (busy > 0) begin
      repeat (busy) @(negedge SYS_CLK);
      check(MEM_PORT_OE, ONES);
      check(MEM_HOLD_STALL, 1'b1);
      @(posedge SYS_CLK);
      MEM_BUSY <= 1'b0;
      @(negedge SYS_CLK);
    end
    cnt(1'b0, '0, n);
    check(n >= (busy > 0 ? 1 : FLOAT_MIN_CYC) && n <= 5, 1'b1);
    cnt(1'b1, '0, n);
    check(n <= GRANT_LAG_MAX_P, 1'b1);
    check(MEM_PORT_OE, '0);
    @(posedge SYS_CLK);
    go <= 1'b0;
    wreq(1'b1);
    cnt(1'b0, ONES, n);
    check(n >= RESUME_MIN_CYC && n <= RESUME_MAX_P, 1'b1);
    cnt(1'b1, 1, n);
    check(n <= GRANT_LAG_MAX_P, 1'b1);
    check(MEM_HOLD_STALL, 1'b0);
  endtask : run
  // ----------------------------------------------------------------------
  // random pin values and the pass-through model
  // ----------------------------------------------------------------------
  always @(posedge SYS_CLK) begin
    if (!seeded) void'($urandom(39601));
    seeded = 1'b1;
    rnd = {$urandom(), $urandom(), $urandom()};
    MEM_PORT_IN <= rnd[MEM_PORT_W-1:0];
  end
  always @(negedge SYS_CLK) begin
    exp_q.push_back(MEM_PORT_IN);
    if (exp_q.size() > 1) begin
      e = exp_q.pop_front();
      if (RSTN && MEM_PORT_OE === ONES) check(MEM_PORT_OUT, e);
    end
  end
  initial begin
    #20000;
    n_mismatch++;
    final_report();
  end
  initial begin
    repeat (5) @(posedge SYS_CLK);
    @(negedge SYS_CLK);
    check(EXTERNAL_BUS_GRANT_N, 1'b1);
    @(posedge SYS_CLK);
    RSTN <= 1'b1;
    run(0);
    run(6);
    // request withdrawn while the drain still waits on the controller
    @(posedge SYS_CLK);
    MEM_BUSY <= 1'b1;
    go <= 1'b1;
    repeat (6) @(negedge SYS_CLK);
    check(MEM_HOLD_STALL, 1'b1);
    @(posedge SYS_CLK);
    go <= 1'b0;
    repeat (6) @(negedge SYS_CLK);
    check({MEM_PORT_OE[0], EXTERNAL_BUS_GRANT_N, MEM_HOLD_STALL}, 3'b110);
    @(posedge SYS_CLK);
    MEM_BUSY <= 1'b0;
    HOLD_DISABLE <= 1'b1;
    go <= 1'b1;
    repeat (20) @(negedge SYS_CLK);
    check({MEM_PORT_OE[0], EXTERNAL_BUS_GRANT_N, MEM_HOLD_STALL}, 3'b110);
    // drop the request first: clearing the disable under a live request grants it
    @(posedge SYS_CLK);
    go <= 1'b0;
    repeat (4) @(posedge SYS_CLK);
    HOLD_DISABLE <= 1'b0;
    run(0);
    final_report();
  end
endmodule : external_bus_hold_grant_test
